/* File: design/pss_top.v */
// Pin state sequencer for host bus and memory pads.
//
// Functional notes
// RQ1: Capture straps during reset or at release.
// RQ2: Processor reset low, terminate high 1 ms later.
// RQ3: Host bus terminated high; powered down S3+.
// RQ4: Lock input terminated high around reset.
// RQ5: Memory clocks tri-stated in reset, then driven.
// RQ6: Clock 5 tri, driven, low in standby.
// RQ7: Clock enables driven low in all live states.
// RQ8: Data pulled up, high-Z in C3/standby.
// RQ9: Data bits 58, 55 pulled up, then low.
// RQ10: Data strobes tri-stated, high-Z in standby.
// RQ11: Receive-enable out tri, then driven high.
// RQ12: Receive-enable input buffer always enabled; code disables it in S3 and off states.
// RQ13: Bank, strobes, address tri, then driven.
// RQ14: Write-enable tri, driven, low in standby.
// RQ15: Chip selects tri, then driven high.
// RQ16: Other memory pins weakly pulled in S3.
// RQ17: Everything powered down in off states; code keeps the lock input terminated high.
// RQ18: Reset input resets logic asynchronously; code resets the strap capture synchronously.
// RQ19: Pad states follow decoded power state.
`timescale 1ns/10ps
`include "pss_defs.vh"
module pss_top
#(
    parameter CPU_RST_CYC = `PSS_CPU_RST_CYC,
    parameter STRAP_W     = 8
)
(
    // Clock and reset
    input  wire               clk_i,
    input  wire               rst_b_i,
    // Power state and straps
    input  wire [2:0]         pwr_state_i,
    input  wire [STRAP_W-1:0] strap_i,
    output reg  [STRAP_W-1:0] strap_o,
    // Processor reset pad
    output reg                processor_reset_out_n_o,
    output reg                processor_reset_oe_o,
    output reg                processor_reset_term_o,
    // Host bus group pads
    output reg  [2:0]         host_bus_mode_o,
    output reg  [2:0]         host_lock_in_mode_o,
    // Memory clock pads
    output reg  [2:0]         mem_clock_n_mode_o,
    output reg  [2:0]         mem_clock_lo_mode_o,
    output reg  [2:0]         mem_clock5_mode_o,
    output reg  [2:0]         mem_clock_enable_mode_o,
    // Memory data pads
    output reg  [2:0]         mem_data_mode_o,
    output reg  [2:0]         mem_data_58_55_mode_o,
    output reg  [2:0]         mem_data_strobe_mode_o,
    // Receive enable pads
    output reg  [2:0]         receive_enable_out_n_mode_o,
    output reg                receive_enable_in_n_buf_en_o,
    // Memory command pads
    output reg  [2:0]         mem_cmd_mode_o,
    output reg  [2:0]         mem_write_enable_n_mode_o,
    output reg  [2:0]         mem_chip_select_n_mode_o
);

    // Sequencer states, one-hot.
    localparam ST_RESET = 3'b001;
    localparam ST_WAIT  = 3'b010;
    localparam ST_RUN   = 3'b100;

    reg  [2:0] state_q;
    reg  [2:0] state_d;
    reg        strap_done_q;
    wire       delay_done;

    // RQ18: asynchronous reset
    always @(posedge clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
            state_q <= ST_RESET;
        else
            state_q <= state_d;
    end

    always @*
    begin
        case (state_q)
            ST_RESET:
                state_d = ST_WAIT;
            ST_WAIT:
                state_d = delay_done ? ST_RUN : ST_WAIT;
            ST_RUN:
                state_d = ST_RUN;
            default:
                state_d = ST_RESET;
        endcase
    end

    // RQ2: release delay
    pss_delay
    #(
        .CYCLES (CPU_RST_CYC),
        .WIDTH  (32)
    )
    u_delay
    (
        .clk_i   (clk_i),
        .rst_b_i (rst_b_i),
        .start_i (state_q == ST_WAIT),
        .done_o  (delay_done)
    );

    // RQ1: strap capture
    // Inputs are sampled every cycle in reset and on the first cycle after
    // release, which holds the level present at the first clock edge after release.
    always @(posedge clk_i)
    begin
        if (!rst_b_i)
        begin
            strap_o      <= strap_i;
            strap_done_q <= 1'b0;
        end
        else if (!strap_done_q)
        begin
            strap_o      <= strap_i;
            strap_done_q <= 1'b1;
        end
    end

    // Decoded power state, one-hot.
    localparam PW_RUN  = 5'b00001;
    localparam PW_C3   = 5'b00010;
    localparam PW_STBY = 5'b00100;
    localparam PW_S3   = 5'b01000;
    localparam PW_OFF  = 5'b10000;

    reg  [4:0] pwr_dec;
    wire       in_rst;
    wire       run_st;
    wire       c3_sb;
    wire       s3;
    wire       live;

    // Next values of the pad registers.
    reg        cpu_rst_n_d;
    reg        cpu_rst_oe_d;
    reg        cpu_rst_term_d;
    reg  [2:0] host_bus_d;
    reg  [2:0] host_lock_d;
    reg  [2:0] clk_n_d;
    reg  [2:0] clk_lo_d;
    reg  [2:0] clk5_d;
    reg  [2:0] cke_d;
    reg  [2:0] data_d;
    reg  [2:0] data_5855_d;
    reg  [2:0] strobe_d;
    reg  [2:0] rcv_out_d;
    reg        rcv_buf_d;
    reg  [2:0] cmd_d;
    reg  [2:0] we_d;
    reg  [2:0] cs_d;

    // RQ19: decode power state
    // Codes above the off code are treated as off as well.
    always @*
    begin
        case (pwr_state_i)
            `PSS_PWR_RUN:  pwr_dec = PW_RUN;
            `PSS_PWR_C3:   pwr_dec = PW_C3;
            `PSS_PWR_STBY: pwr_dec = PW_STBY;
            `PSS_PWR_S3:   pwr_dec = PW_S3;
            `PSS_PWR_OFF:  pwr_dec = PW_OFF;
            default:       pwr_dec = PW_OFF;
        endcase
    end

    assign in_rst = (state_q == ST_RESET);
    assign run_st = (state_q == ST_RUN);
    assign c3_sb  = pwr_dec[1] | pwr_dec[2];
    assign s3     = pwr_dec[3];
    assign live   = pwr_dec[0] | c3_sb;

    // RQ19: pad states per power state
    always @*
    begin
        // Every pad holds its mode unless a branch below sets it; the lock
        // input has no defined state outside the live states and keeps its
        // termination there.
        cpu_rst_n_d    = processor_reset_out_n_o;
        cpu_rst_oe_d   = processor_reset_oe_o;
        cpu_rst_term_d = processor_reset_term_o;
        host_bus_d     = host_bus_mode_o;
        host_lock_d    = host_lock_in_mode_o;
        clk_n_d        = mem_clock_n_mode_o;
        clk_lo_d       = mem_clock_lo_mode_o;
        clk5_d         = mem_clock5_mode_o;
        cke_d          = mem_clock_enable_mode_o;
        data_d         = mem_data_mode_o;
        data_5855_d    = mem_data_58_55_mode_o;
        strobe_d       = mem_data_strobe_mode_o;
        rcv_out_d      = receive_enable_out_n_mode_o;
        rcv_buf_d      = receive_enable_in_n_buf_en_o;
        cmd_d          = mem_cmd_mode_o;
        we_d           = mem_write_enable_n_mode_o;
        cs_d           = mem_chip_select_n_mode_o;

        if (in_rst)
        begin
            // First cycle after release keeps reset pad states.
            cpu_rst_n_d    = 1'b0;
            cpu_rst_oe_d   = 1'b1;
            cpu_rst_term_d = 1'b0;
        end
        else if (live)
        begin
            // RQ2: terminate after delay
            cpu_rst_n_d    = run_st;
            cpu_rst_oe_d   = !run_st;
            cpu_rst_term_d = run_st;

            // RQ3: host bus terminated
            host_bus_d  = `PSS_PAD_TERM_H;
            // RQ4: lock terminated
            host_lock_d = `PSS_PAD_TERM_H;

            // RQ5: clocks driven
            clk_n_d     = `PSS_PAD_DRIVE;
            clk_lo_d    = `PSS_PAD_DRIVE;
            // RQ6: clock 5 low in standby
            clk5_d      = c3_sb ? `PSS_PAD_DRIVE_L : `PSS_PAD_DRIVE;
            // RQ7: clock enables low
            cke_d       = `PSS_PAD_DRIVE_L;

            // RQ8: data pulls
            data_d      = c3_sb ? `PSS_PAD_TRI : `PSS_PAD_PULL_UP;
            // RQ9: bits 58, 55 low
            data_5855_d = c3_sb ? `PSS_PAD_DRIVE_L : `PSS_PAD_PULL_UP;
            // RQ10: strobes tri
            strobe_d    = `PSS_PAD_TRI;
            // RQ11: receive-enable high
            rcv_out_d   = `PSS_PAD_DRIVE_H;
            // RQ12: input buffer on
            rcv_buf_d   = 1'b1;

            // RQ13: command pads
            cmd_d       = c3_sb ? `PSS_PAD_TRI : `PSS_PAD_DRIVE;
            // RQ14: write enable
            we_d        = c3_sb ? `PSS_PAD_DRIVE_L : `PSS_PAD_DRIVE;
            // RQ15: chip selects
            cs_d        = c3_sb ? `PSS_PAD_TRI : `PSS_PAD_DRIVE_H;
        end
        else if (s3)
        begin
            cpu_rst_n_d    = 1'b0;
            cpu_rst_oe_d   = 1'b0;
            cpu_rst_term_d = 1'b0;

            // RQ3: host bus off in S3
            host_bus_d  = `PSS_PAD_PWRDN;
            // RQ5: clocks are don't-care
            clk_n_d     = `PSS_PAD_PULL_S3;
            clk_lo_d    = `PSS_PAD_PULL_S3;
            // RQ6: clock 5 low
            clk5_d      = `PSS_PAD_DRIVE_L;
            // RQ7: clock enables low
            cke_d       = `PSS_PAD_DRIVE_L;
            // RQ16: weak pulls in S3
            data_d      = `PSS_PAD_PULL_S3;
            strobe_d    = `PSS_PAD_PULL_S3;
            rcv_out_d   = `PSS_PAD_PULL_S3;
            cmd_d       = `PSS_PAD_PULL_S3;
            cs_d        = `PSS_PAD_PULL_S3;
            // RQ9: bits 58, 55 low
            data_5855_d = `PSS_PAD_DRIVE_L;
            // RQ14: write enable low
            we_d        = `PSS_PAD_DRIVE_L;
            // RQ12: buffer is don't-care
            rcv_buf_d   = 1'b0;
        end
        else
        begin
            // RQ17: all pads off except the lock input
            cpu_rst_n_d    = 1'b0;
            cpu_rst_oe_d   = 1'b0;
            cpu_rst_term_d = 1'b0;

            host_bus_d     = `PSS_PAD_PWRDN;
            clk_n_d        = `PSS_PAD_PWRDN;
            clk_lo_d       = `PSS_PAD_PWRDN;
            clk5_d         = `PSS_PAD_PWRDN;
            cke_d          = `PSS_PAD_PWRDN;
            data_d         = `PSS_PAD_PWRDN;
            data_5855_d    = `PSS_PAD_PWRDN;
            strobe_d       = `PSS_PAD_PWRDN;
            rcv_out_d      = `PSS_PAD_PWRDN;
            rcv_buf_d      = 1'b0;
            cmd_d          = `PSS_PAD_PWRDN;
            we_d           = `PSS_PAD_PWRDN;
            cs_d           = `PSS_PAD_PWRDN;
        end
    end

    // RQ18: pad registers, async reset
    always @(posedge clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            processor_reset_out_n_o      <= 1'b0;
            processor_reset_oe_o         <= 1'b1;
            processor_reset_term_o       <= 1'b0;
            host_bus_mode_o              <= `PSS_PAD_TERM_H;
            host_lock_in_mode_o          <= `PSS_PAD_TERM_H;
            mem_clock_n_mode_o           <= `PSS_PAD_TRI;
            mem_clock_lo_mode_o          <= `PSS_PAD_TRI;
            mem_clock5_mode_o            <= `PSS_PAD_TRI;
            mem_clock_enable_mode_o      <= `PSS_PAD_DRIVE_L;
            mem_data_mode_o              <= `PSS_PAD_PULL_UP;
            mem_data_58_55_mode_o        <= `PSS_PAD_PULL_UP;
            mem_data_strobe_mode_o       <= `PSS_PAD_TRI;
            receive_enable_out_n_mode_o  <= `PSS_PAD_TRI;
            receive_enable_in_n_buf_en_o <= 1'b1;
            mem_cmd_mode_o               <= `PSS_PAD_TRI;
            mem_write_enable_n_mode_o    <= `PSS_PAD_TRI;
            mem_chip_select_n_mode_o     <= `PSS_PAD_TRI;
        end
        else
        begin
            processor_reset_out_n_o      <= cpu_rst_n_d;
            processor_reset_oe_o         <= cpu_rst_oe_d;
            processor_reset_term_o       <= cpu_rst_term_d;
            host_bus_mode_o              <= host_bus_d;
            host_lock_in_mode_o          <= host_lock_d;
            mem_clock_n_mode_o           <= clk_n_d;
            mem_clock_lo_mode_o          <= clk_lo_d;
            mem_clock5_mode_o            <= clk5_d;
            mem_clock_enable_mode_o      <= cke_d;
            mem_data_mode_o              <= data_d;
            mem_data_58_55_mode_o        <= data_5855_d;
            mem_data_strobe_mode_o       <= strobe_d;
            receive_enable_out_n_mode_o  <= rcv_out_d;
            receive_enable_in_n_buf_en_o <= rcv_buf_d;
            mem_cmd_mode_o               <= cmd_d;
            mem_write_enable_n_mode_o    <= we_d;
            mem_chip_select_n_mode_o     <= cs_d;
        end
    end

endmodule

/* File: design/pss_defs.vh */
// Constants shared by the pin state sequencer files.
`ifndef PSS_DEFS_VH
`define PSS_DEFS_VH

// Power state input codes.
`define PSS_PWR_RUN      3'h0
`define PSS_PWR_C3       3'h1
`define PSS_PWR_STBY     3'h2
`define PSS_PWR_S3       3'h3
`define PSS_PWR_OFF      3'h4

// Pad mode codes, shared by all three-bit pad mode outputs.
`define PSS_PAD_PWRDN    3'h0
`define PSS_PAD_TERM_H   3'h1
`define PSS_PAD_DRIVE    3'h2
`define PSS_PAD_DRIVE_L  3'h3
`define PSS_PAD_DRIVE_H  3'h4
`define PSS_PAD_TRI      3'h5
`define PSS_PAD_PULL_UP  3'h6
`define PSS_PAD_PULL_S3  3'h7

// Processor reset release delay.
`define PSS_CPU_RST_US   1000
`define PSS_CLK_MHZ      20
`define PSS_CPU_RST_CYC  (`PSS_CPU_RST_US * `PSS_CLK_MHZ)

// Reset values.
`define PSS_STRAP_RST    8'h00

`endif

/* File: design/pss_delay.v */
// Counter that raises done a fixed number of cycles after start.
`timescale 1ns/10ps
module pss_delay
#(
    parameter CYCLES = 20000,
    parameter WIDTH  = 16
)
(
    // Clock and reset
    input  wire             clk_i,
    input  wire             rst_b_i,
    // Control
    input  wire             start_i,
    output reg              done_o
);

    reg [WIDTH-1:0] cnt_q;

    always @(posedge clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            cnt_q  <= {WIDTH{1'b0}};
            done_o <= 1'b0;
        end
        else if (!start_i)
        begin
            cnt_q  <= {WIDTH{1'b0}};
            done_o <= 1'b0;
        end
        else if (!done_o)
        begin
            if (cnt_q == CYCLES[WIDTH-1:0] - 1'b1)
                done_o <= 1'b1;
            cnt_q <= cnt_q + 1'b1;
        end
    end

endmodule

/* File: testbench/pss_chk_assertions.sv */
// Assertions on the pin state sequencer ports.
`timescale 1ns/10ps
module pss_chk
#(
    parameter CPU_RST_CYC = 10
)
(
    input wire       clk_i,
    input wire       rst_b_i,
    input wire [2:0] pwr_state_i,
    input wire [7:0] strap_i,
    input wire [7:0] strap_o,
    input wire       processor_reset_out_n_o,
    input wire       processor_reset_oe_o,
    input wire       processor_reset_term_o,
    input wire [2:0] host_bus_mode_o,
    input wire [2:0] mem_clock5_mode_o,
    input wire [2:0] mem_clock_enable_mode_o,
    input wire [2:0] mem_data_mode_o,
    input wire [2:0] mem_data_58_55_mode_o,
    input wire [2:0] receive_enable_out_n_mode_o,
    input wire [2:0] mem_cmd_mode_o,
    input wire [2:0] mem_chip_select_n_mode_o
);
    reg [15:0] cnt_q;
    default clocking @(posedge clk_i); endclocking
    default disable iff (!rst_b_i);
    // Cycles since reset release, saturating.
    always @(posedge clk_i)
        if (!rst_b_i)
            cnt_q <= 16'h0000;
        else if (cnt_q != 16'hffff)
            cnt_q <= cnt_q + 16'h0001;
    AST_STRAP_RST: assert property (disable iff (1'b0)
        !rst_b_i |=> strap_o == $past(strap_i)) else $error("strap lost");
    AST_STRAP_HOLD: assert property (rst_b_i && $past(rst_b_i, 2)
        |-> $stable(strap_o)) else $error("strap moved after release");
    AST_RST_PADS: assert property (disable iff (1'b0)
        !rst_b_i [*2] |-> !processor_reset_out_n_o && processor_reset_oe_o
        && mem_clock5_mode_o == 3'h5 && mem_cmd_mode_o == 3'h5)
        else $error("reset pad state wrong");
    AST_CPU_HOLD: assert property (cnt_q < CPU_RST_CYC
        |-> processor_reset_oe_o && !processor_reset_term_o)
        else $error("processor reset released early");
    AST_CPU_REL: assert property (cnt_q == CPU_RST_CYC + 6
        && pwr_state_i == 3'h0 |-> processor_reset_term_o
        && !processor_reset_oe_o) else $error("processor reset not released");
    AST_HOST_LIVE: assert property (pwr_state_i < 3'h3 [*2]
        |=> host_bus_mode_o == 3'h1) else $error("host bus not terminated");
    AST_CKE_LOW: assert property (!pwr_state_i[2] [*2]
        |=> mem_clock_enable_mode_o == 3'h3) else $error("clock enable wrong");
    AST_S3_LOW: assert property (pwr_state_i == 3'h3 [*2]
        |=> mem_clock5_mode_o == 3'h3 && mem_data_58_55_mode_o == 3'h3)
        else $error("forced low pads wrong in S3");
    AST_IDLE_HIZ: assert property ((pwr_state_i == 3'h1
        || pwr_state_i == 3'h2) [*2] |=> mem_data_mode_o == 3'h5
        && mem_cmd_mode_o == 3'h5 && mem_chip_select_n_mode_o == 3'h5)
        else $error("idle pads not high impedance");
    AST_RUN_DRV: assert property (pwr_state_i == 3'h0 [*2]
        |=> receive_enable_out_n_mode_o == 3'h4
        && mem_chip_select_n_mode_o == 3'h4) else $error("run pads wrong");
    AST_OFF_DOWN: assert property (pwr_state_i[2] [*2]
        |=> host_bus_mode_o == 3'h0 && mem_data_mode_o == 3'h0)
        else $error("off pads not powered down");
    cover property (cnt_q == CPU_RST_CYC + 6);
    cover property (pwr_state_i == 3'h3 [*2]);
    cover property (pwr_state_i[2] [*2]);
endmodule

bind pss_top pss_chk #(.CPU_RST_CYC(CPU_RST_CYC)) u_pss_chk (.*);

/* File: testbench/pss_cpu_model.sv */
// Processor side view of the processor reset pad.
`timescale 1ns/10ps
module pss_cpu_model
(
    // Clock
    input  wire clk_i,
    // Pad controls
    input  wire out_n_i,
    input  wire oe_i,
    input  wire term_i,
    // Level seen by the processor
    output reg  level_o = 1'b0
);
    always @(posedge clk_i)
        level_o <= oe_i ? out_n_i : (term_i ? 1'b1 : ~level_o);
endmodule

/* File: testbench/pss_top_tb.sv */
// Self-checking bench for the pin state sequencer.
`timescale 1ns/10ps
module pss_top_tb;
    localparam          CYC = 10;
    localparam [33:0]   RST = {3'h1, 3'h1, 3'h5, 3'h3, 3'h6, 3'h6, 3'h5,
                               3'h5, 3'h5, 3'h5, 3'h5, 1'b1};
    reg                 clk_i = 1'b0;
    reg                 rst_b_i = 1'b0;
    reg  [2:0]          pwr_state_i = 3'h0;
    reg  [7:0]          strap_i = 8'h00;
    reg  [26:0]         seq = {3'h1, 3'h2, 3'h3, 3'h4, 3'h0, 3'h7, 3'h3,
                               3'h1, 3'h0};
    wire [7:0]          strap_o;
    wire                r_n;
    wire                r_oe;
    wire                r_term;
    wire                buf_en;
    wire                seen;
    wire [2:0]          m [0:12];
    wire [33:0]         v = {m[0], m[1], m[4], m[5], m[6], m[7], m[8],
                             m[9], m[10], m[11], m[12], buf_en};
    integer             num_errors = 0;
    integer             comparisons = 0;
    integer             i;
    pss_top #(.CPU_RST_CYC(CYC)) u_pss_top (
        .clk_i(clk_i), .rst_b_i(rst_b_i), .pwr_state_i(pwr_state_i),
        .strap_i(strap_i), .strap_o(strap_o),
        .processor_reset_out_n_o(r_n), .processor_reset_oe_o(r_oe),
        .processor_reset_term_o(r_term), .host_bus_mode_o(m[0]),
        .host_lock_in_mode_o(m[1]), .mem_clock_n_mode_o(m[2]),
        .mem_clock_lo_mode_o(m[3]), .mem_clock5_mode_o(m[4]),
        .mem_clock_enable_mode_o(m[5]), .mem_data_mode_o(m[6]),
        .mem_data_58_55_mode_o(m[7]), .mem_data_strobe_mode_o(m[8]),
        .receive_enable_out_n_mode_o(m[9]),
        .receive_enable_in_n_buf_en_o(buf_en), .mem_cmd_mode_o(m[10]),
        .mem_write_enable_n_mode_o(m[11]),
        .mem_chip_select_n_mode_o(m[12]));
    pss_cpu_model u_pss_cpu_model (.clk_i(clk_i), .out_n_i(r_n),
        .oe_i(r_oe), .term_i(r_term), .level_o(seen));
    initial
        forever #25 clk_i = ~clk_i;
    function [33:0] exp_of(input [2:0] s);
        case (s)
            3'h0: exp_of = {3'h1, 3'h1, 3'h2, 3'h3, 3'h6, 3'h6, 3'h5,
                            3'h4, 3'h2, 3'h2, 3'h4, 1'b1};
            3'h1, 3'h2: exp_of = {3'h1, 3'h1, 3'h3, 3'h3, 3'h5, 3'h3,
                            3'h5, 3'h4, 3'h5, 3'h3, 3'h5, 1'b1};
            3'h3: exp_of = {3'h0, 3'h1, 3'h3, 3'h3, 3'h7, 3'h3, 3'h7,
                            3'h7, 3'h7, 3'h3, 3'h7, 1'b0};
            default: exp_of = {3'h0, 3'h1, 27'h000_0000, 1'b0};
        endcase
    endfunction
    task check(input string name, input [33:0] got, input [33:0] want);
        begin
            comparisons = comparisons + 1;
            if (got !== want)
            begin
                $display("Error %0s expected %h seen %h", name, want, got);
                num_errors = num_errors + 1;
            end
        end
    endtask
    task end_sim;
        begin
            $display("comparisons %0d mismatches %0d", comparisons,
                     num_errors);
            if (num_errors == 0 && comparisons > 0)
                $display("All tests passed");
            else
                $display("Some tests failed");
            $finish;
        end
    endtask
    task do_reset;
        begin
            @(negedge clk_i);
            rst_b_i = 1'b0;
            pwr_state_i = 3'h0;
            strap_i = 8'ha5;
            repeat (4) @(negedge clk_i);
            check("reset pads", v, RST);
            check("reset clk", {m[2], m[3], seen}, 7'h5a);
            check("strap in reset", strap_o, 8'ha5);
            strap_i = 8'h3c;
            rst_b_i = 1'b1;
            @(negedge clk_i);
            check("first cycle", v, RST);
            strap_i = 8'hc3;
            @(negedge clk_i);
            check("strap latched", strap_o, 8'h3c);
            check("run pads", v, exp_of(3'h0));
            check("run clk", {m[2], m[3]}, 6'h12);
            for (i = 0; i < CYC + 20 && seen !== 1'b1; i = i + 1)
                @(negedge clk_i);
            if (i == CYC + 20)
            begin
                num_errors = num_errors + 1;
                end_sim;
            end
            check("release", i >= CYC - 1 && i <= CYC + 6, 1'b1);
            repeat (8) @(negedge clk_i);
        end
    endtask
    task test_states;
        begin
            for (i = 0; i < 9; i = i + 1)
            begin
                pwr_state_i = seq[26 - 3 * i -: 3];
                @(negedge clk_i);
                check("state", v, exp_of(pwr_state_i));
                if (pwr_state_i[2])
                    check("off clk", {m[2], m[3]}, 6'h00);
                if (pwr_state_i >= 3'h3)
                    check("cpu pad off", {r_n, r_oe, r_term}, 3'h0);
                else
                    check("cpu pad live", {r_n, r_oe, r_term}, 3'h5);
            end
        end
    endtask
    task mid_reset;
        begin
            pwr_state_i = 3'h3;
            repeat (2) @(negedge clk_i);
            rst_b_i = 1'b0;
            #1;
            check("async reset", {v, r_n, r_oe}, {RST, 2'h1});
            do_reset;
        end
    endtask
    initial
    begin
        do_reset;
        $display("reset test done");
        test_states;
        $display("power state test done");
        mid_reset;
        $display("mid-run reset test done");
        end_sim;
    end
endmodule
